//--- ir_led_partner.sv
// led driver model: measures infrared high widths and resolves the indicator line
`timescale 1ns/1ps
module ir_led_partner (
  input  wire logic ref_clk,
  input  wire logic ir_drive_pin,
  input  wire logic busy_indicator_pin,
  input  wire logic busy_indicator_oe_n,
  output logic      indicator_line,
  output int        last_width
);
  int run = 0;
  initial last_width = 0;
  // a released pin falls to the pull-down level
  assign indicator_line = busy_indicator_oe_n ? 1'b0 : busy_indicator_pin;
  always @(posedge ref_clk) begin
    if (ir_drive_pin) run++;
    else if (run != 0) begin
      last_width = run;
      run = 0;
    end
  end
endmodule

//--- ir_pattern_timer.sv
// infrared pattern timer with carrier generator and transmission indicator
// Functional notes
// - pulse timer has 9-bit down counter, output-enable flag and zero detector
// - loading nonzero count starts counter; loading zero leaves timer stopped
// - running counter decrements once every 64 oscillator periods
// - at zero counting stops; end signal asserts after a further 64 periods, held while zero
// - end signal releases timer-wait halt; execution resumes after halt
// - output time (value+1)*64 periods; shortened variant 4 periods less
// - shortened variant: back-to-back loads total 4 periods shorter than sum
// - enable set and running: indicator low, infrared high or carrier
// - infrared low if ended or disabled; carrier or steady high by disable bit
// - carrier generator: 9-bit counter plus high and low period registers
// - carrier counter at twice oscillator; phases last period value plus one ticks
// - bit 9 of low period register is fixed zero
// - bit 9 of high period register clear selects carrier, set steady level
// - carrier output starts with its low phase
// - end signal stops carrier, infrared low; running high phase completes first
// - period registers readable and writable as nibbles or full 10 bits
// - entering oscillator-stopped standby halts timer and clears count
// - in clock-running halt the timer keeps running with its outputs
// - indicator pin drives only in output mode
`timescale 1ns/1ps
module ir_pattern_timer
  import ir_timer_pkg::*;
#(
  parameter int  REF_DIVIDE    = ir_timer_pkg::REF_PER_CARRIER_TICK,
  parameter bit  SHORT_VARIANT = 1'b0
) (
  input  wire logic                     ref_clk,
  input  wire logic                     reset,
  input  wire ir_timer_pkg::timer_cmd_t cmd,
  output ir_timer_pkg::timer_rsp_t      rsp,
  input  wire logic                     halt_wait,
  input  wire logic                     stop_standby,
  input  wire logic                     indicator_output_mode,
  output logic                          halt_release,
  output logic                          timer_end,
  output logic                          ir_drive_pin,
  output logic                          busy_indicator_pin,
  output logic                          busy_indicator_oe_n
);
  import ir_timer_pkg::*;

  localparam logic [PRESCALE_W-1:0] PRESCALE_LAST  = PRESCALE_W'(OSC_PER_DECREMENT - 1);
  localparam logic [PRESCALE_W-1:0] PRESCALE_START = SHORT_VARIANT ?
                                                     PRESCALE_W'(SHORTEN_OSC) : '0;

  generate
    if (REF_DIVIDE < 1) begin : g_bad_div
      $error("ir_pattern_timer: REF_DIVIDE must be at least 1");
    end
  endgenerate

  // derived rates
  logic carrier_tick;
  logic osc_tick;

  tick_divider #(.DIVIDE(REF_DIVIDE)) u_carrier_div (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .enable_in (1'b1),
    .tick      (carrier_tick)
  );

  tick_divider #(.DIVIDE(CARRIER_TICKS_PER_OSC)) u_osc_div (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .enable_in (carrier_tick),
    .tick      (osc_tick)
  );

  // register state
  logic [COUNT_W-1:0]    count;
  logic                  pulse_output_enable;
  logic                  tail;
  logic [PRESCALE_W-1:0] prescale;
  logic [REG_W-1:0]      carrier_low_period;
  logic [REG_W-1:0]      carrier_high_period;
  logic [COUNT_W-1:0]    carrier_count;
  carrier_state_t        carrier_state;

  logic       carrier_disable;
  logic       count_zero;
  logic       busy;
  logic       timer_wr;
  logic [REG_W-1:0] next_timer;
  logic       start_load;

  assign carrier_disable = carrier_high_period[CARRIER_DISABLE_BIT];
  assign count_zero      = (count == COUNT_ZERO);
  // the extra period after the last decrement gives the value+1 output length
  assign busy            = !count_zero || tail;
  assign timer_wr        = cmd.wr && (cmd.sel == SEL_TIMER);

  // merge a full or nibble write into the current value
  function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] cur,
                                             input access_t acc,
                                             input logic [REG_W-1:0] wdata);
    logic [REG_W-1:0] res;
    res = cur;
    case (acc)
      ACC_FULL:    res = wdata;
      ACC_NIBBLE0: res[NIBBLE_W-1:0] = wdata[NIBBLE_W-1:0];
      ACC_NIBBLE1: res[2*NIBBLE_W-1:NIBBLE_W] = wdata[NIBBLE_W-1:0];
      default:     res = cur;
    endcase
    return res;
  endfunction

  function automatic logic [REG_W-1:0] pick(input logic [REG_W-1:0] cur,
                                            input access_t acc);
    logic [REG_W-1:0] res;
    res = '0;
    case (acc)
      ACC_FULL:    res = cur;
      ACC_NIBBLE0: res[NIBBLE_W-1:0] = cur[NIBBLE_W-1:0];
      ACC_NIBBLE1: res[NIBBLE_W-1:0] = cur[2*NIBBLE_W-1:NIBBLE_W];
      default:     res = '0;
    endcase
    return res;
  endfunction

  assign next_timer = merge({pulse_output_enable, count}, cmd.acc, cmd.data);
  // a load starts a fresh pattern only when the timer was idle
  assign start_load = timer_wr && (next_timer[COUNT_W-1:0] != COUNT_ZERO) && !busy;

  // output-enable flag and down counter
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      count               <= TIMER_RESET[COUNT_W-1:0];
      pulse_output_enable <= TIMER_RESET[ENABLE_BIT];
    end else if (stop_standby) begin
      count               <= COUNT_ZERO;
      pulse_output_enable <= 1'b0;
    end else if (timer_wr) begin
      pulse_output_enable <= next_timer[ENABLE_BIT];
      count               <= next_timer[COUNT_W-1:0];
    end else if (osc_tick && !count_zero && prescale == PRESCALE_LAST) begin
      count <= count - COUNT_W'(1);
    end
  end

  // tail period after the counter reaches zero
  always_ff @(posedge ref_clk) begin
    if (reset || stop_standby) begin
      tail <= 1'b0;
    end else if (timer_wr) begin
      tail <= next_timer[COUNT_W-1:0] != COUNT_ZERO;
    end else if (osc_tick && prescale == PRESCALE_LAST && count_zero) begin
      tail <= 1'b0;
    end
  end

  // 64-period prescaler; shortened variant starts the first period 4 counts in, so it is 4 periods short
  always_ff @(posedge ref_clk) begin
    if (reset || stop_standby) begin
      prescale <= '0;
    end else if (start_load) begin
      prescale <= PRESCALE_START;
    end else if (osc_tick && busy) begin
      prescale <= (prescale == PRESCALE_LAST) ? '0 : prescale + PRESCALE_W'(1);
    end
  end

  // low and high period registers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      carrier_low_period <= PERIOD_RESET;
    end else if (cmd.wr && cmd.sel == SEL_LOW_PERIOD) begin
      carrier_low_period <= merge(carrier_low_period, cmd.acc, cmd.data);
      carrier_low_period[LOW_PAD_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      carrier_high_period <= PERIOD_RESET;
    end else if (cmd.wr && cmd.sel == SEL_HIGH_PERIOD) begin
      carrier_high_period <= merge(carrier_high_period, cmd.acc, cmd.data);
    end
  end

  // read answer, one cycle after the request
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rsp <= '0;
    end else begin
      rsp.valid <= cmd.rd;
      case (cmd.sel)
        SEL_TIMER:       rsp.data <= pick({pulse_output_enable, count}, cmd.acc);
        SEL_LOW_PERIOD:  rsp.data <= pick(carrier_low_period, cmd.acc);
        SEL_HIGH_PERIOD: rsp.data <= pick(carrier_high_period, cmd.acc);
        default:         rsp.data <= '0;
      endcase
    end
  end

  // carrier generator at twice the oscillator rate
  logic [COUNT_W-1:0] phase_last;
  assign phase_last = (carrier_state == CAR_HIGH) ? carrier_high_period[COUNT_W-1:0]
                                                  : carrier_low_period[COUNT_W-1:0];

  always_ff @(posedge ref_clk) begin
    if (reset || stop_standby) begin
      carrier_state <= CAR_IDLE;
      carrier_count <= '0;
    end else if (start_load) begin
      carrier_state <= CAR_LOW;
      carrier_count <= '0;
    end else if (carrier_tick) begin
      case (carrier_state)
        CAR_IDLE: begin
          carrier_count <= '0;
        end
        CAR_LOW: begin
          if (!busy) begin
            carrier_state <= CAR_IDLE;
            carrier_count <= '0;
          end else if (carrier_count == phase_last) begin
            carrier_state <= CAR_HIGH;
            carrier_count <= '0;
          end else begin
            carrier_count <= carrier_count + COUNT_W'(1);
          end
        end
        CAR_HIGH: begin
          if (carrier_count == phase_last) begin
            carrier_state <= busy ? CAR_LOW : CAR_IDLE;
            carrier_count <= '0;
          end else begin
            carrier_count <= carrier_count + COUNT_W'(1);
          end
        end
        default: begin
          carrier_state <= CAR_IDLE;
          carrier_count <= '0;
        end
      endcase
    end
  end

  // pin and status outputs, all registered; they keep running in clock-running halt
  logic next_ir;
  logic next_led;
  always_comb begin
    if (!pulse_output_enable) begin
      next_ir = 1'b0;
    end else if (carrier_disable) begin
      next_ir = busy;
    end else begin
      next_ir = (carrier_state == CAR_HIGH);
    end
    next_led = !(pulse_output_enable && busy);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ir_drive_pin <= 1'b0;
    end else begin
      ir_drive_pin <= next_ir;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      busy_indicator_pin  <= 1'b1;
      busy_indicator_oe_n <= 1'b1;
    end else begin
      busy_indicator_pin  <= next_led;
      busy_indicator_oe_n <= !indicator_output_mode;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      timer_end    <= 1'b1;
      halt_release <= 1'b0;
    end else begin
      timer_end    <= !busy;
      halt_release <= halt_wait && !busy;
    end
  end
endmodule

//--- ir_pattern_timer_assertions.sv
// port checker for the infrared pattern timer
`timescale 1ns/1ps
module ir_pattern_timer_assertions
  import ir_timer_pkg::*;
(
  input wire logic                     ref_clk,
  input wire logic                     reset,
  input wire ir_timer_pkg::timer_cmd_t cmd,
  input wire ir_timer_pkg::timer_rsp_t rsp,
  input wire logic                     halt_wait,
  input wire logic                     stop_standby,
  input wire logic                     indicator_output_mode,
  input wire logic                     halt_release,
  input wire logic                     timer_end,
  input wire logic                     ir_drive_pin,
  input wire logic                     busy_indicator_pin,
  input wire logic                     busy_indicator_oe_n
);
  logic timer_wr;
  assign timer_wr = cmd.wr && cmd.sel == SEL_TIMER && cmd.acc == ACC_FULL;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  reset_outputs_a: assert property ($past(reset) |-> !ir_drive_pin && timer_end)
    else $error("outputs wrong after reset");
  zero_load_a: assert property (timer_wr && cmd.data[8:0] == 9'h000 |-> ##2 timer_end)
    else $error("zero load did not leave timer stopped");
  start_load_a: assert property (timer_wr && cmd.data[8:0] != 9'h000 && !stop_standby
    |-> ##2 (!timer_end && busy_indicator_pin != $past(cmd.data[9], 2)))
    else $error("nonzero load did not start timer");
  read_answer_a: assert property (cmd.rd |=> rsp.valid)
    else $error("read not answered");
  answer_cause_a: assert property (rsp.valid |-> $past(cmd.rd))
    else $error("answer without read");
  indicator_busy_a: assert property (!busy_indicator_pin |-> !timer_end)
    else $error("indicator low while timer idle");
  halt_release_a: assert property (!$past(reset) |-> halt_release == ($past(halt_wait) && timer_end))
    else $error("halt release wrong");
  indicator_mode_a: assert property (!$past(reset) |-> busy_indicator_oe_n == !$past(indicator_output_mode))
    else $error("indicator drive mode wrong");
  standby_clear_a: assert property (stop_standby |-> ##2 timer_end)
    else $error("standby did not stop timer");
  cover property (rsp.valid);
  cover property (halt_release);
  cover property (!busy_indicator_pin && ir_drive_pin);
endmodule

bind ir_pattern_timer ir_pattern_timer_assertions i_ir_pattern_timer_assertions (
  .ref_clk(ref_clk), .reset(reset), .cmd(cmd), .rsp(rsp), .halt_wait(halt_wait),
  .stop_standby(stop_standby), .indicator_output_mode(indicator_output_mode),
  .halt_release(halt_release), .timer_end(timer_end), .ir_drive_pin(ir_drive_pin),
  .busy_indicator_pin(busy_indicator_pin), .busy_indicator_oe_n(busy_indicator_oe_n));

//--- ir_pattern_timer_bench.sv
// self-checking bench for the infrared pattern timer
`timescale 1ns/1ps
module ir_pattern_timer_bench;
  import ir_timer_pkg::*;
  localparam int DIV = 1;
  localparam int DEC_CYC = OSC_PER_DECREMENT * CARRIER_TICKS_PER_OSC * DIV;
  logic       ref_clk = 0, reset = 1, halt_wait = 0, stop_standby = 0, mode = 1;
  timer_cmd_t cmd = '0;
  timer_rsp_t rsp;
  logic       halt_release, timer_end, ir, ind, ind_oe_n, ind_line;
  logic [9:0] model [4] = '{10'h000, 10'h001, 10'h001, 10'h000};
  int         last_width, e, n, n_fail = 0, samples_checked = 0, cycles = 0, seed = 20;
  ir_pattern_timer #(.REF_DIVIDE(DIV), .SHORT_VARIANT(1'b0)) i_ir_pattern_timer (
    .ref_clk(ref_clk), .reset(reset), .cmd(cmd), .rsp(rsp), .halt_wait(halt_wait),
    .stop_standby(stop_standby), .indicator_output_mode(mode), .halt_release(halt_release),
    .timer_end(timer_end), .ir_drive_pin(ir), .busy_indicator_pin(ind),
    .busy_indicator_oe_n(ind_oe_n));
  ir_led_partner i_ir_led_partner (.ref_clk(ref_clk), .ir_drive_pin(ir),
    .busy_indicator_pin(ind), .busy_indicator_oe_n(ind_oe_n),
    .indicator_line(ind_line), .last_width(last_width));
  initial forever #2 ref_clk = ~ref_clk;
  task automatic check(string what, logic [9:0] exp, logic [9:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(reg_sel_t s, access_t a, logic [9:0] d);
    @(posedge ref_clk);
    cmd <= '{1'b1, 1'b0, s, a, d};
    if (a == ACC_FULL) model[s] = d;
    else if (a == ACC_NIBBLE0) model[s][3:0] = d[3:0];
    else model[s][7:4] = d[3:0];
    model[1][9] = 1'b0;
    model[3] = 10'h000;
    @(posedge ref_clk);
    cmd <= '0;
  endtask
  task automatic rd(reg_sel_t s, access_t a);
    logic [9:0] x;
    x = a == ACC_FULL ? model[s] : {6'h00, a == ACC_NIBBLE0 ? model[s][3:0] : model[s][7:4]};
    @(posedge ref_clk);
    cmd <= '{1'b0, 1'b1, s, a, 10'h000};
    @(posedge ref_clk);
    cmd <= '0;
    #1;
    check("rsp valid", 10'h001, {9'h000, rsp.valid});
    check("rsp data", x, rsp.data);
  endtask
  task automatic wait_idle();
    for (int k = 0; k < 8000 && timer_end !== 1'b1; k++) @(posedge ref_clk);
    repeat (8) @(posedge ref_clk);
    #1;
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      complete_run();
    end
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    for (int s = 0; s < 4; s++) rd(reg_sel_t'(s), ACC_FULL);
    for (int i = 0; i < 6; i++) begin
      wr(SEL_LOW_PERIOD, access_t'(i % 3), 10'h200 | 10'($random(seed)) | 10'h001);
      wr(SEL_HIGH_PERIOD, access_t'(i % 3), 10'($random(seed)) | 10'h001);
      wr(reg_sel_t'(3), ACC_FULL, 10'h3ff);
      for (int a = 0; a < 3; a++) rd(SEL_LOW_PERIOD, access_t'(a));
      for (int a = 0; a < 3; a++) rd(SEL_HIGH_PERIOD, access_t'(a));
      rd(reg_sel_t'(3), ACC_FULL);
    end
    $display("test registers done");
    for (int i = 0; i < 3; i++) begin
      wr(SEL_HIGH_PERIOD, ACC_FULL, 10'h201);
      halt_wait <= 1'b1;
      n = ($random(seed) & 3) + 1;
      e = (n + 1) * DEC_CYC;
      wr(SEL_TIMER, ACC_FULL, 10'h200 | 10'(n));
      repeat (4) @(posedge ref_clk);
      #1;
      check("ir steady", 10'h001, {9'h000, ir});
      check("indicator", 10'h000, {9'h000, ind_line});
      check("halt held", 10'h000, {9'h000, halt_release});
      wait_idle();
      check("width ok", 10'h001, {9'h000, last_width >= e - 2 && last_width <= e + 4});
      check("halt released", 10'h001, {9'h000, halt_release});
      check("ir idle", 10'h000, {9'h000, ir});
      halt_wait <= 1'b0;
    end
    $display("test steady pulse done");
    mode <= 1'b0;
    wr(SEL_TIMER, ACC_FULL, 10'h200);
    repeat (3) @(posedge ref_clk);
    #1;
    check("released oe", 10'h001, {9'h000, ind_oe_n});
    check("zero load idle", 10'h001, {9'h000, timer_end});
    mode <= 1'b1;
    wr(SEL_TIMER, ACC_FULL, 10'h27f);
    repeat (3) @(posedge ref_clk);
    stop_standby <= 1'b1;
    @(posedge ref_clk);
    stop_standby <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    check("standby idle", 10'h001, {9'h000, timer_end});
    model[0] = 10'h000;
    rd(SEL_TIMER, ACC_FULL);
    $display("test zero and standby done");
    wr(SEL_LOW_PERIOD, ACC_FULL, 10'h003);
    wr(SEL_HIGH_PERIOD, ACC_FULL, 10'h002);
    wr(SEL_TIMER, ACC_FULL, 10'h201);
    @(posedge ref_clk);
    #1;
    check("carrier starts low", 10'h000, {9'h000, ir});
    wait_idle();
    check("carrier high", 10'h003, 10'(last_width));
    check("carrier stopped", 10'h000, {9'h000, ir});
    $display("test carrier done");
    complete_run();
  end
endmodule

//--- ir_timer_pkg.sv
// shared constants and types for the infrared pattern timer and carrier generator
package ir_timer_pkg;

  localparam int COUNT_W    = 9;
  localparam int REG_W      = 10;
  localparam int NIBBLE_W   = 4;
  localparam int ENABLE_BIT = 9;
  localparam int CARRIER_DISABLE_BIT   = 9;
  localparam int LOW_PAD_BIT = 9;

  // ref_clk is 250 MHz; the oscillator rate is derived from it by division
  localparam int REF_CLK_HZ       = 250_000_000;
  localparam int MAIN_OSC_FREQ_HZ = 4_000_000;
  localparam int CARRIER_TICK_HZ  = 2 * MAIN_OSC_FREQ_HZ;
  // rounded down: the closest whole divide of ref_clk to twice the oscillator rate
  localparam int REF_PER_CARRIER_TICK = REF_CLK_HZ / CARRIER_TICK_HZ;
  localparam int CARRIER_TICKS_PER_OSC = CARRIER_TICK_HZ / MAIN_OSC_FREQ_HZ;

  localparam int OSC_PER_DECREMENT = 64;
  localparam int SHORTEN_OSC       = 4;
  localparam int PRESCALE_W        = 6;

  localparam logic [COUNT_W-1:0] COUNT_ZERO   = 9'h000;
  localparam logic [REG_W-1:0]   TIMER_RESET  = 10'h000;
  localparam logic [REG_W-1:0]   PERIOD_RESET = 10'h001;

  typedef enum logic [1:0] {
    SEL_TIMER       = 2'h0,
    SEL_LOW_PERIOD  = 2'h1,
    SEL_HIGH_PERIOD = 2'h2
  } reg_sel_t;

  typedef enum logic [1:0] {
    ACC_FULL   = 2'h0,
    ACC_NIBBLE0 = 2'h1,
    ACC_NIBBLE1 = 2'h2
  } access_t;

  typedef struct packed {
    logic             wr;
    logic             rd;
    reg_sel_t         sel;
    access_t          acc;
    logic [REG_W-1:0] data;
  } timer_cmd_t;

  typedef struct packed {
    logic             valid;
    logic [REG_W-1:0] data;
  } timer_rsp_t;

  typedef enum logic [2:0] {
    CAR_IDLE = 3'b001,
    CAR_LOW  = 3'b010,
    CAR_HIGH = 3'b100
  } carrier_state_t;

endpackage

//--- tick_divider.sv
// enable divider: one-cycle pulse every DIVIDE qualified input enables
`timescale 1ns/1ps
module tick_divider #(
  parameter int DIVIDE = 2
) (
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic enable_in,
  output logic      tick
);
  localparam int CW = (DIVIDE > 1) ? $clog2(DIVIDE) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIVIDE - 1);

  logic [CW-1:0] count;

  generate
    if (DIVIDE < 1) begin : g_bad
      $error("tick_divider: DIVIDE must be at least 1");
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      count <= '0;
    end else if (enable_in) begin
      count <= (count == LAST) ? '0 : count + CW'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tick <= 1'b0;
    end else begin
      tick <= enable_in && (count == LAST);
    end
  end
endmodule
